// ==== design/dlcs_pkg.sv ====
// Package of constants for the debug link control and status registers
package dlcs_pkg;
  // Register offsets
  localparam logic [3:0] DLCS_OFS_REV   = 4'h0;
  localparam logic [3:0] DLCS_OFS_ERR   = 4'h1;
  localparam logic [3:0] DLCS_OFS_LCTL  = 4'h2;
  localparam logic [3:0] DLCS_OFS_LOPT  = 4'h3;
  localparam logic [3:0] DLCS_OFS_KEY   = 4'h7;
  localparam logic [3:0] DLCS_OFS_RST   = 4'h8;
  localparam logic [3:0] DLCS_OFS_CSEL  = 4'h9;
  localparam logic [3:0] DLCS_OFS_SCTL  = 4'ha;
  localparam logic [3:0] DLCS_OFS_SSTAT = 4'hb;
  localparam logic [3:0] DLCS_OFS_CRC   = 4'hc;
  // Field positions
  localparam int DLCS_BIT_IBD   = 7;
  localparam int DLCS_BIT_PAR   = 5;
  localparam int DLCS_BIT_TMO   = 4;
  localparam int DLCS_BIT_RSP   = 3;
  localparam int DLCS_BIT_NACK  = 4;
  localparam int DLCS_BIT_CCD   = 3;
  localparam int DLCS_BIT_DIS   = 2;
  localparam int DLCS_BIT_UROW  = 5;
  localparam int DLCS_BIT_PROG  = 4;
  localparam int DLCS_BIT_ERASE = 3;
  localparam int DLCS_BIT_UDONE = 1;
  localparam int DLCS_BIT_CREQ  = 0;
  // Writable masks
  localparam logic [7:0] DLCS_LCTL_MASK = 8'hbf;
  localparam logic [7:0] DLCS_LOPT_MASK = 8'h1c;
  // Reset values and the reset request signature
  localparam logic [7:0] DLCS_CSEL_RST  = 8'h03;
  localparam logic [7:0] DLCS_SCTL_RST  = 8'h01;
  localparam logic [7:0] DLCS_RST_RUN   = 8'h00;
  localparam logic [7:0] DLCS_RST_SIG   = 8'h59;
  // Error codes
  localparam logic [2:0] DLCS_ERR_NONE  = 3'h0;
  localparam logic [2:0] DLCS_ERR_PAR   = 3'h1;
  localparam logic [2:0] DLCS_ERR_FRM   = 3'h2;
  localparam logic [2:0] DLCS_ERR_TMO   = 3'h3;
  localparam logic [2:0] DLCS_ERR_CLK   = 3'h4;
  localparam logic [2:0] DLCS_ERR_BUS   = 3'h6;
  localparam logic [2:0] DLCS_ERR_CONT  = 3'h7;
  // Timeout in interface clock cycles
  localparam int DLCS_TMO_CYCLES = 65536;
  // Inter-byte gap in idle bits
  localparam int DLCS_IBD_BITS   = 2;
  // Guard time reserved code
  localparam logic [2:0] DLCS_GT_RSVD = 3'h7;
endpackage

// ==== design/dlcs_err_if.sv ====
// Interface carrying raw link error events to the error capture
`timescale 1ns/1ps
`default_nettype none
interface dlcs_err_if;
  logic parity_err;   // Parity sample wrong
  logic stop_err;     // Stop bit sample wrong
  logic start_err;    // Start bit sample wrong
  logic timeout_err;  // Access layer timed out
  logic bus_err;      // Address or privilege error
  logic cont_err;     // Pin contention seen
  logic parity_off;   // Parity ignored
  logic cont_off;     // Contention check off
  modport src (output parity_err, stop_err, start_err, timeout_err,
               bus_err, cont_err, input parity_off, cont_off);
  modport dst (input parity_err, stop_err, start_err, timeout_err,
               bus_err, cont_err, output parity_off, cont_off);
endinterface
`default_nettype wire

// ==== design/dlcs_timeout.sv ====
// Access layer response timeout counter
`timescale 1ns/1ps
`default_nettype none
module dlcs_timeout #(
  parameter int TMO_CYCLES = dlcs_pkg::DLCS_TMO_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic wait_start,  // Request sent to access layer
  input  wire logic acc_resp,    // Access layer answered
  input  wire logic check_off,   // Timeout detection disabled
  output logic      expired      // One-cycle timeout pulse
);
  typedef struct packed {
    logic        busy;
    logic [16:0] cnt;
    logic        exp;
  } dlcs_tmo_s;
  dlcs_tmo_s st_r;   // Registered state
  dlcs_tmo_s st_nxt; // Next state

  // Count while waiting; fire once at the limit
  always_comb begin
    st_nxt     = st_r;
    st_nxt.exp = 1'b0;
    if (wait_start) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt  = '0;
    end else if (acc_resp || check_off) begin
      // Disabling mid-wait drops the wait without a flag
      st_nxt.busy = 1'b0;
    end else if (st_r.busy) begin
      if (st_r.cnt == 17'(TMO_CYCLES - 1)) begin
        st_nxt.exp  = 1'b1;
        st_nxt.busy = 1'b0;
      end else begin
        st_nxt.cnt = st_r.cnt + 17'h1;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expired = st_r.exp;
endmodule
`default_nettype wire

// ==== design/dlcs_err_capture.sv ====
// Error signature capture with clear on read
`timescale 1ns/1ps
`default_nettype none
module dlcs_err_capture (
  input  wire logic ref_clk,
  input  wire logic srst,
  dlcs_err_if.dst   ev,
  input  wire logic parity_off_in,
  input  wire logic cont_off_in,
  input  wire logic rd_clear,    // Debugger read of the signature
  output logic [2:0] sig
);
  typedef struct packed {
    logic [2:0] sig;
  } dlcs_ecap_s;
  dlcs_ecap_s st_r;
  dlcs_ecap_s st_nxt;

  assign ev.parity_off = parity_off_in;
  assign ev.cont_off   = cont_off_in;

  // Priority picks one code when events coincide; a new event wins a read
  always_comb begin
    st_nxt = st_r;
    if (rd_clear) begin
      st_nxt.sig = dlcs_pkg::DLCS_ERR_NONE;
    end
    if (ev.cont_err && !cont_off_in) begin
      st_nxt.sig = dlcs_pkg::DLCS_ERR_CONT;
    end else if (ev.bus_err) begin
      st_nxt.sig = dlcs_pkg::DLCS_ERR_BUS;
    end else if (ev.timeout_err) begin
      st_nxt.sig = dlcs_pkg::DLCS_ERR_TMO;
    end else if (ev.start_err) begin
      st_nxt.sig = dlcs_pkg::DLCS_ERR_CLK;
    end else if (ev.stop_err) begin
      st_nxt.sig = dlcs_pkg::DLCS_ERR_FRM;
    end else if (ev.parity_err && !parity_off_in) begin
      st_nxt.sig = dlcs_pkg::DLCS_ERR_PAR;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sig = st_r.sig;
endmodule
`default_nettype wire

// ==== design/dlcs_regs.sv ====
// Control and status register space of the debug link
`timescale 1ns/1ps
`default_nettype none
module dlcs_regs #(
  parameter logic [3:0] REVISION   = 4'h5, // Arbitrary revision value
  parameter int         TMO_CYCLES = dlcs_pkg::DLCS_TMO_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // Control-space access from the link layer only
  input  wire logic       cs_wr,
  input  wire logic       cs_rd,
  input  wire logic [3:0] cs_addr,
  input  wire logic [7:0] cs_wdata,
  output logic [7:0]      cs_rdata,
  // Raw link events
  input  wire logic       parity_err,
  input  wire logic       stop_err,
  input  wire logic       start_err,
  input  wire logic       bus_err,
  input  wire logic       cont_err,
  input  wire logic       acc_wait_start,
  input  wire logic       acc_resp,
  // Key decode and system status
  input  wire logic       urow_key_ok,
  input  wire logic       prog_key_ok,
  input  wire logic       erase_key_ok,
  input  wire logic       programming_start_flag,
  input  wire logic [7:0] sys_status,
  input  wire logic [7:0] crc_status,
  // Control outputs to the link layer
  output logic            inter_byte_delay_enable,
  output logic            parity_check_off,
  output logic            timeout_check_off,
  output logic            response_signature_off,
  output logic            negative_ack_off,
  output logic            contention_check_off,
  output logic [7:0]      guard_cycles,
  output logic [1:0]      ibd_idle_bits,
  output logic            link_enable,
  output logic            system_clock_request,
  output logic            user_row_done,
  output logic            system_reset,
  output logic [1:0]      link_clock_sel
);
  typedef struct packed {
    logic [7:0] lctl;
    logic [7:0] lopt;
    logic       urow_key;
    logic       prog_key;
    logic       erase_key;
    logic [7:0] rst_req;
    logic [7:0] csel;
    logic [7:0] sctl;
    logic       disabled;
    logic [7:0] rdata;
  } dlcs_regs_s;
  dlcs_regs_s st_r;
  dlcs_regs_s st_nxt;

  logic       tmo_exp;  // Timeout pulse
  logic [2:0] err_sig;  // Captured error code
  logic       rd_err;   // Read of the error register
  logic       rst_wr;   // Write to reset request
  logic       erase_rst;// Reset signature written to reset request

  dlcs_err_if err_bus ();
  assign err_bus.parity_err  = parity_err;
  assign err_bus.stop_err    = stop_err;
  assign err_bus.start_err   = start_err;
  assign err_bus.timeout_err = tmo_exp;
  assign err_bus.bus_err     = bus_err;
  assign err_bus.cont_err    = cont_err;

  // Response watchdog toward the access layer
  dlcs_timeout #(
    .TMO_CYCLES(TMO_CYCLES)
  ) u_tmo (
    .ref_clk    (ref_clk),
    .srst       (srst || st_r.disabled),
    .wait_start (acc_wait_start),
    .acc_resp   (acc_resp),
    .check_off  (st_r.lctl[dlcs_pkg::DLCS_BIT_TMO]),
    .expired    (tmo_exp)
  );

  // Error signature with clear on read
  dlcs_err_capture u_err (
    .ref_clk       (ref_clk),
    .srst          (srst || st_r.disabled),
    .ev            (err_bus.dst),
    .parity_off_in (st_r.lctl[dlcs_pkg::DLCS_BIT_PAR]),
    .cont_off_in   (st_r.lopt[dlcs_pkg::DLCS_BIT_CCD]),
    .rd_clear      (rd_err),
    .sig           (err_sig)
  );

  assign rd_err = cs_rd && (cs_addr == dlcs_pkg::DLCS_OFS_ERR);
  assign rst_wr = cs_wr && (cs_addr == dlcs_pkg::DLCS_OFS_RST);
  assign erase_rst = rst_wr && (cs_wdata == dlcs_pkg::DLCS_RST_SIG);

  // Register updates, key tracking and read data
  always_comb begin
    st_nxt = st_r;
    // Keys set on decode; decode wins a same-cycle clear, but an interface disable clears them
    if (cs_wr && cs_addr == dlcs_pkg::DLCS_OFS_KEY &&
        cs_wdata[dlcs_pkg::DLCS_BIT_UROW]) begin
      st_nxt.urow_key = 1'b0;
    end
    if (urow_key_ok) begin
      st_nxt.urow_key = 1'b1;
    end
    if (programming_start_flag) begin
      st_nxt.prog_key = 1'b0;
    end
    if (prog_key_ok) begin
      st_nxt.prog_key = 1'b1;
    end
    if (erase_rst) begin
      st_nxt.erase_key = 1'b0;
    end
    if (erase_key_ok) begin
      st_nxt.erase_key = 1'b1;
    end
    // Register writes; reserved bits masked off
    if (cs_wr) begin
      unique case (cs_addr)
        dlcs_pkg::DLCS_OFS_LCTL: begin
          st_nxt.lctl = cs_wdata & dlcs_pkg::DLCS_LCTL_MASK;
        end
        dlcs_pkg::DLCS_OFS_LOPT: begin
          st_nxt.lopt = cs_wdata & dlcs_pkg::DLCS_LOPT_MASK;
        end
        dlcs_pkg::DLCS_OFS_RST: begin
          st_nxt.rst_req = cs_wdata;
        end
        dlcs_pkg::DLCS_OFS_CSEL: begin
          // Code zero is reserved; keep the old selection
          if (cs_wdata[1:0] != 2'h0) begin
            st_nxt.csel = {6'h00, cs_wdata[1:0]};
          end
        end
        dlcs_pkg::DLCS_OFS_SCTL: begin
          st_nxt.sctl[dlcs_pkg::DLCS_BIT_CREQ] =
            cs_wdata[dlcs_pkg::DLCS_BIT_CREQ];
          // Done bit settable only while user row key held; otherwise a write clears it
          st_nxt.sctl[dlcs_pkg::DLCS_BIT_UDONE] = st_r.urow_key &&
            cs_wdata[dlcs_pkg::DLCS_BIT_UDONE];
        end
        default: begin
          // Read-only or unmapped: writes ignored here; the key write clear is handled above
        end
      endcase
    end
    // Interface disable: drop configuration, keys and clock request
    if (cs_wr && cs_addr == dlcs_pkg::DLCS_OFS_LOPT &&
        cs_wdata[dlcs_pkg::DLCS_BIT_DIS]) begin
      st_nxt.disabled  = 1'b1;
      st_nxt.lctl      = 8'h00;
      st_nxt.lopt      = 8'h00;
      st_nxt.urow_key  = 1'b0;
      st_nxt.prog_key  = 1'b0;
      st_nxt.erase_key = 1'b0;
      st_nxt.sctl      = 8'h00;
      st_nxt.csel      = dlcs_pkg::DLCS_CSEL_RST;
    end
    // Read data from flip-flops; only the link port reaches here
    st_nxt.rdata = 8'h00;
    if (cs_rd) begin
      unique case (cs_addr)
        dlcs_pkg::DLCS_OFS_REV:   st_nxt.rdata = {REVISION, 4'h0};
        dlcs_pkg::DLCS_OFS_ERR:   st_nxt.rdata = {5'h00, err_sig};
        dlcs_pkg::DLCS_OFS_LCTL:  st_nxt.rdata = st_r.lctl;
        dlcs_pkg::DLCS_OFS_LOPT:  st_nxt.rdata = st_r.lopt;
        dlcs_pkg::DLCS_OFS_KEY:   st_nxt.rdata = {2'h0, st_r.urow_key,
                                    st_r.prog_key, st_r.erase_key, 3'h0};
        dlcs_pkg::DLCS_OFS_RST:   st_nxt.rdata = st_r.rst_req;
        dlcs_pkg::DLCS_OFS_CSEL:  st_nxt.rdata = st_r.csel;
        dlcs_pkg::DLCS_OFS_SCTL:  st_nxt.rdata = st_r.sctl;
        dlcs_pkg::DLCS_OFS_SSTAT: st_nxt.rdata = sys_status;
        dlcs_pkg::DLCS_OFS_CRC:   st_nxt.rdata = {5'h00, crc_status[2:0]};
        default:                  st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register; system reset request never resets this block
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r         <= '0;
      st_r.csel    <= dlcs_pkg::DLCS_CSEL_RST;
      st_r.sctl    <= dlcs_pkg::DLCS_SCTL_RST;
      st_r.rst_req <= dlcs_pkg::DLCS_RST_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Guard time from code; reserved code falls back to longest
  always_comb begin
    if (st_r.lctl[2:0] == dlcs_pkg::DLCS_GT_RSVD) begin
      guard_cycles = 8'h80;
    end else begin
      guard_cycles = 8'(9'h080 >> st_r.lctl[2:0]);
    end
  end

  assign ibd_idle_bits = st_r.lctl[dlcs_pkg::DLCS_BIT_IBD] ?
    2'(dlcs_pkg::DLCS_IBD_BITS) : 2'h0;
  assign inter_byte_delay_enable = st_r.lctl[dlcs_pkg::DLCS_BIT_IBD];
  assign parity_check_off = st_r.lctl[dlcs_pkg::DLCS_BIT_PAR];
  assign timeout_check_off = st_r.lctl[dlcs_pkg::DLCS_BIT_TMO];
  assign response_signature_off = st_r.lctl[dlcs_pkg::DLCS_BIT_RSP];
  assign negative_ack_off = st_r.lopt[dlcs_pkg::DLCS_BIT_NACK];
  assign contention_check_off = st_r.lopt[dlcs_pkg::DLCS_BIT_CCD];
  assign link_enable = !st_r.disabled;
  assign system_clock_request = st_r.sctl[dlcs_pkg::DLCS_BIT_CREQ] &&
    !st_r.disabled;
  assign user_row_done = st_r.sctl[dlcs_pkg::DLCS_BIT_UDONE];
  // Only the signature holds reset; zero and others release
  assign system_reset = (st_r.rst_req == dlcs_pkg::DLCS_RST_SIG);
  assign link_clock_sel = st_r.csel[1:0];
  assign cs_rdata = st_r.rdata;
endmodule
`default_nettype wire

// ==== bench/dlcs_regs_asserts.sv ====
// Port-level checker for the debug link register block
`timescale 1ns/1ps
`default_nettype none
module dlcs_regs_asserts #(
  parameter logic [3:0] REVISION   = 4'h5,
  parameter int         TMO_CYCLES = 16
) (
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       cs_wr,
  input wire logic       cs_rd,
  input wire logic [3:0] cs_addr,
  input wire logic [7:0] cs_wdata,
  input wire logic [7:0] cs_rdata,
  input wire logic       parity_err,
  input wire logic       stop_err,
  input wire logic       start_err,
  input wire logic       bus_err,
  input wire logic       cont_err,
  input wire logic       inter_byte_delay_enable,
  input wire logic       parity_check_off,
  input wire logic       timeout_check_off,
  input wire logic       negative_ack_off,
  input wire logic       contention_check_off,
  input wire logic [7:0] guard_cycles,
  input wire logic [1:0] ibd_idle_bits,
  input wire logic       link_enable,
  input wire logic       system_clock_request,
  input wire logic       system_reset
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Any error port event, timeout excluded; a read with one pending is not a clean clear
  wire logic ev = parity_err | stop_err | start_err | bus_err | cont_err;
  wire logic rd1 = cs_rd && cs_addr == 4'h1 && !ev;
  wire logic wr2 = cs_wr && cs_addr == 4'h2 && link_enable;
  wire logic wr3 = cs_wr && cs_addr == 4'h3 && link_enable;
  wire logic wr8 = cs_wr && cs_addr == 4'h8;
  logic [7:0] wd_r;  // Last write data, for one-cycle-late compare
  always_ff @(posedge ref_clk) wd_r <= cs_wdata;
  // Timeout kept off so no hidden error lands meanwhile
  sequence s_clr; rd1 && timeout_check_off; endsequence
  sequence s_par;
    parity_err && !(stop_err | start_err | bus_err | cont_err)
      && !parity_check_off && timeout_check_off;
  endsequence
  property p_rd_idle; !cs_rd |=> cs_rdata == 8'h00; endproperty
  property p_rev;
    cs_rd && cs_addr == 4'h0 |=> cs_rdata == {REVISION, 4'h0};
  endproperty
  property p_clr; s_clr ##1 s_clr |=> cs_rdata == 8'h00; endproperty
  property p_par; s_par ##1 rd1 |=> cs_rdata == 8'h01; endproperty
  property p_ctl;
    wr2 |=> guard_cycles == (8'h80 >> wd_r[2:0]) || wd_r[2:0] == 3'h7;
  endproperty
  property p_ctl_bits;
    wr2 |=> parity_check_off == wd_r[5] && timeout_check_off == wd_r[4]
      && inter_byte_delay_enable == wd_r[7];
  endproperty
  property p_ibd; inter_byte_delay_enable |-> ibd_idle_bits == 2'h2;
  endproperty
  property p_opt;
    wr3 && !cs_wdata[2] |=> negative_ack_off == wd_r[4]
      && contention_check_off == wd_r[3];
  endproperty
  property p_dis;
    wr3 && cs_wdata[2] |=> (!link_enable && !system_clock_request)[*3];
  endproperty
  property p_rst;
    wr8 && cs_wdata == 8'h59 && link_enable |=> system_reset && link_enable;
  endproperty
  property p_run; wr8 && cs_wdata == 8'h00 |=> !system_reset; endproperty
  property p_clk; system_clock_request |-> link_enable; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  a_rev: assert property (p_rev) else $error("revision wrong");
  a_clr: assert property (p_clr) else $error("not cleared");
  a_par: assert property (p_par) else $error("parity code");
  a_ctl: assert property (p_ctl) else $error("guard time");
  a_ctl_bits: assert property (p_ctl_bits) else $error("ctl");
  a_ibd: assert property (p_ibd) else $error("gap bits");
  a_opt: assert property (p_opt) else $error("opt bits");
  a_dis: assert property (p_dis) else $error("disable");
  a_rst: assert property (p_rst) else $error("reset req");
  a_run: assert property (p_run) else $error("reset hold");
  a_clk: assert property (p_clk) else $error("clock req");
endmodule
bind dlcs_regs dlcs_regs_asserts #(.REVISION(REVISION),
  .TMO_CYCLES(TMO_CYCLES)) chk_u (.*);
`default_nettype wire

// ==== bench/dlcs_acc_model.sv ====
// Access layer stand-in answering link requests after a set delay
`timescale 1ns/1ps
`default_nettype none
module dlcs_acc_model (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       acc_wait_start,
  input  wire logic [7:0] lat,
  output logic            acc_resp
);
  int cnt;  // Cycles left until the answer
  // A latency of zero never answers, forcing the link timeout
  always @(posedge ref_clk) begin
    acc_resp <= 1'b0;
    if (srst) cnt <= 0;
    else if (acc_wait_start) cnt <= lat;
    else if (cnt > 0) begin
      cnt <= cnt - 1;
      acc_resp <= (cnt == 1);
    end
  end
endmodule
`default_nettype wire

// ==== bench/dlcs_regs_bench.sv ====
// Self-checking bench for the debug link register block
`timescale 1ns/1ps
`default_nettype none
module dlcs_regs_bench;
  logic ref_clk = 1'b0, srst = 1'b1, cs_wr = 1'b0, cs_rd = 1'b0;
  logic [3:0] cs_addr = 4'h0;
  logic [7:0] cs_wdata = 8'h00, sys_status = 8'h00, crc_status = 8'h00;
  logic [7:0] lat = 8'h00, cs_rdata, guard_cycles, d;
  logic parity_err = 1'b0, stop_err = 1'b0, start_err = 1'b0;
  logic bus_err = 1'b0, cont_err = 1'b0, acc_wait_start = 1'b0;
  logic urow_key_ok = 1'b0, prog_key_ok = 1'b0, erase_key_ok = 1'b0;
  logic programming_start_flag = 1'b0, acc_resp, rd_pend = 1'b0;
  logic inter_byte_delay_enable, parity_check_off, timeout_check_off;
  logic response_signature_off, negative_ack_off, contention_check_off;
  logic link_enable, system_clock_request, user_row_done, system_reset;
  logic [1:0] ibd_idle_bits, link_clock_sel;
  logic [7:0] exp_q[$];  // Expected read data, oldest first
  int n_mismatch = 0, samples_checked = 0;
  // Reset image: offset and expected value, unmapped 4 last
  logic [3:0] ofs[9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'ha, 4'h4};
  logic [7:0] rv[9] = '{8'h50, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03,
                        8'h01, 8'h00};
  dlcs_regs #(.TMO_CYCLES(16)) dut_u (.*);
  dlcs_acc_model acc_u (.*);
  always #5 ref_clk = ~ref_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Strobes drop by NBA at the edge so reads may run back to back
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    cs_wr = 1'b1;
    cs_addr = a;
    cs_wdata = v;
    @(posedge ref_clk);
    cs_wr <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    cs_rd = 1'b1;
    cs_addr = a;
    exp_q.push_back(e);
    @(posedge ref_clk);
    cs_rd <= 1'b0;
  endtask
  // Drop just after the edge; a ref argument may not take a deferred write
  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1'b1;
    @(posedge ref_clk);
    #1 s = 1'b0;
  endtask
  // Read data stands one cycle after the strobe
  always @(posedge ref_clk) rd_pend <= cs_rd;
  always @(negedge ref_clk) if (rd_pend) chk(cs_rdata, exp_q.pop_front());
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
  initial begin
    void'($urandom(28499));
    repeat (20) @(negedge ref_clk);
    srst = 1'b0;
    foreach (ofs[i]) rd(ofs[i], rv[i]);
    @(negedge ref_clk);
    chk(system_clock_request, 1'b1);
    sys_status = 8'($urandom);
    crc_status = 8'($urandom);
    rd(4'hb, sys_status);
    rd(4'hc, {5'h00, crc_status[2:0]});
    wr(4'h0, 8'hff);
    rd(4'h0, 8'h50);
    // Every guard code, guard time checked for codes 0 to 6 only, plus random control bits, reserved bit 6 too
    for (int i = 0; i < 8; i++) begin
      d = (8'($urandom) & 8'hf8) | 8'(i);
      wr(4'h2, d);
      if (i < 7) chk(guard_cycles, 8'h80 >> i);
      chk({inter_byte_delay_enable, 1'b0, parity_check_off, timeout_check_off,
           response_signature_off, 3'h0}, d & 8'hb8);
      rd(4'h2, d & 8'hbf);
      wr(4'h3, 8'($urandom) & 8'hfb);
      rd(4'h3, cs_wdata & 8'h18);
    end
    wr(4'h3, 8'h00);
    wr(4'h2, 8'h10);
    pulse(parity_err); rd(4'h1, 8'h01);
    pulse(stop_err); rd(4'h1, 8'h02);
    pulse(start_err); rd(4'h1, 8'h04);
    pulse(bus_err); rd(4'h1, 8'h06);
    pulse(cont_err); rd(4'h1, 8'h07); rd(4'h1, 8'h00);
    wr(4'h2, 8'h30);
    pulse(parity_err); rd(4'h1, 8'h00);
    wr(4'h3, 8'h08);
    pulse(cont_err); rd(4'h1, 8'h00);
    // Prompt answer, then silence with and without timeout checking
    wr(4'h2, 8'h00);
    lat = 8'h03;
    pulse(acc_wait_start);
    repeat (30) @(posedge ref_clk);
    rd(4'h1, 8'h00);
    lat = 8'h00;
    pulse(acc_wait_start);
    repeat (30) @(posedge ref_clk);
    rd(4'h1, 8'h03);
    wr(4'h2, 8'h10);
    pulse(acc_wait_start);
    repeat (30) @(posedge ref_clk);
    rd(4'h1, 8'h00);
    pulse(urow_key_ok); pulse(prog_key_ok); pulse(erase_key_ok);
    rd(4'h7, 8'h38);
    pulse(programming_start_flag); rd(4'h7, 8'h28);
    wr(4'h8, 8'h59);
    chk(system_reset, 1'b1);
    rd(4'h7, 8'h20);
    wr(4'h7, 8'h20); rd(4'h7, 8'h00);
    wr(4'h8, 8'h00);
    chk({system_reset, link_enable}, 8'h01);
    wr(4'h9, 8'h01); wr(4'h9, 8'h00); rd(4'h9, 8'h01);
    wr(4'ha, 8'h00);
    chk(system_clock_request, 1'b0);
    wr(4'ha, 8'h01);
    chk(system_clock_request, 1'b1);
    wr(4'h2, 8'hb8);
    wr(4'h3, 8'h04);
    chk({link_enable, system_clock_request}, 8'h00);
    rd(4'h2, 8'h00);
    repeat (4) @(negedge ref_clk);
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    rd(4'h3, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk(link_enable, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
